// ---- rtl/hbr_link_if.sv ----
/*
  Carrier between the requester end and the router end: three request
  channels with valid/ready and the initialisation settings.
  Assumes both ends share one clock; the bench instantiates and joins them.
*/
`default_nettype none
interface hbr_link_if;
  logic                   host_valid;
  logic                   host_ready;
  hbr_pkg::hbr_host_req_t host;
  logic                   peer_valid;
  logic                   peer_ready;
  hbr_pkg::hbr_peer_req_t peer;
  logic                   agpq_valid;
  logic                   agpq_ready;
  hbr_pkg::hbr_agpq_req_t agpq;
  // Settings, stable once init_valid rises
  logic                   init_valid;
  logic                   mech_sba;
  logic                   agent_pci;
  logic                   ext_gfx;
  hbr_pkg::hbr_rate_t     agp_rate;
  logic [7:0]             link_ver;

  modport dev (
    input  host_valid, host, peer_valid, peer, agpq_valid, agpq,
    input  init_valid, mech_sba, agent_pci, ext_gfx, agp_rate, link_ver,
    output host_ready, peer_ready, agpq_ready
  );
  modport req (
    output host_valid, host, peer_valid, peer, agpq_valid, agpq,
    output init_valid, mech_sba, agent_pci, ext_gfx, agp_rate, link_ver,
    input  host_ready, peer_ready, agpq_ready
  );
endinterface : hbr_link_if
`default_nettype wire

// ---- rtl/hbr_pkg.sv ----
/*
  Shared constants, enumerations and cycle records for the host bridge
  cycle router: the router end and the requester end both use them.
  Assumes a single 20 MHz clock for both ends and synchronous inputs.
*/
`default_nettype none
package hbr_pkg;
  // Clocking of this model
  localparam int          HBR_CLK_PERIOD_NS = 50;
  // Address space: 32-bit host addresses, 4 GB decode
  localparam int          HBR_ADDR_W        = 32;
  localparam int          HBR_PAGE_BITS     = 12;
  localparam int          HBR_PFN_W         = HBR_ADDR_W - HBR_PAGE_BITS;
  // Configuration space reached by I/O at the address and data ports
  localparam logic [31:0] HBR_CFG_ADDR_PORT = 32'h0000_0cf8;
  localparam logic [31:0] HBR_CFG_DATA_PORT = 32'h0000_0cfc;
  // Graphics request queue
  localparam int          HBR_AGPQ_DEPTH    = 32;
  localparam int          HBR_APER_PAGES    = 16;
  // Hub-style link protocol: version 1.0, 266 MT/s on a 66 MHz base
  localparam logic [7:0]  HBR_LINK_VER      = 8'h10;
  localparam int          HBR_LINK_MTS      = 266;
  localparam int          HBR_LINK_BASE_MHZ = 66;
  localparam int          HBR_PCI_AGENT_MHZ = 66;

  typedef enum logic [1:0] {HBR_TGT_MEM, HBR_TGT_AGP, HBR_TGT_LINK, HBR_TGT_CFG} hbr_target_t;
  typedef enum logic [1:0] {HBR_SRC_HOST, HBR_SRC_PEER, HBR_SRC_AGPQ, HBR_SRC_IGU} hbr_source_t;
  typedef enum logic [1:0] {HBR_PEER_AGP, HBR_PEER_HUB, HBR_PEER_LAN} hbr_peer_t;
  typedef enum logic [1:0] {HBR_RATE_1X, HBR_RATE_2X, HBR_RATE_4X, HBR_RATE_8X} hbr_rate_t;
  typedef enum logic [1:0] {HBR_HCLK_100, HBR_HCLK_133, HBR_HCLK_200, HBR_HCLK_BAD} hbr_hclk_t;

  typedef struct packed {
    logic        is_io;
    logic        wr;
    logic [31:0] addr;
  } hbr_host_req_t;

  typedef struct packed {
    hbr_peer_t   src;
    logic        agp_sem;
    logic        noncache;
    logic        wr;
    logic [31:0] addr;
  } hbr_peer_req_t;

  typedef struct packed {
    logic        hp;
    logic        via_sba;
    logic        wr;
    logic [31:0] addr;
  } hbr_agpq_req_t;

  typedef struct packed {
    hbr_source_t src;
    hbr_target_t tgt;
    logic        drop;
    logic        snoop;
    logic        wr;
    logic [31:0] addr;
  } hbr_route_t;
endpackage : hbr_pkg
`default_nettype wire

// ---- rtl/hbr_requester.sv ----
/*
  Requester end: presents host, peer and graphics-queue cycles to the
  router through one-entry holding registers and fixes the settings.
  Assumes user-side sources hold valid until ready, one shared clock.
*/
`default_nettype none
module hbr_requester (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  // Router end
  hbr_link_if.req                     lnk,
  // Settings, sampled once after reset
  input  wire logic                   mech_sba_i,
  input  wire logic                   agent_pci_i,
  input  wire logic                   ext_gfx_i,
  input  wire hbr_pkg::hbr_rate_t     agp_rate_i,
  // Host cycles
  input  wire logic                   host_valid_i,
  input  wire hbr_pkg::hbr_host_req_t host_i,
  output logic                        host_ready_o,
  // Peer cycles
  input  wire logic                   peer_valid_i,
  input  wire hbr_pkg::hbr_peer_req_t peer_i,
  output logic                        peer_ready_o,
  // Graphics queue requests
  input  wire logic                   agpq_valid_i,
  input  wire logic                   agpq_hp_i,
  input  wire logic                   agpq_wr_i,
  input  wire logic [31:0]            agpq_addr_i,
  output logic                        agpq_ready_o
);
  logic                   init_done, mech_sba, agent_pci, ext_gfx;
  hbr_pkg::hbr_rate_t     agp_rate;
  logic                   host_v, peer_v, agpq_v, next_host_v, next_peer_v, next_agpq_v;
  hbr_pkg::hbr_host_req_t host_q, next_host_q;
  hbr_pkg::hbr_peer_req_t peer_q, next_peer_q;
  hbr_pkg::hbr_agpq_req_t agpq_q, next_agpq_q;

  // Settings frozen before any queue traffic may start
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_done <= 1'b0;
      mech_sba  <= 1'b0;
      agent_pci <= 1'b0;
      ext_gfx   <= 1'b0;
      agp_rate  <= hbr_pkg::HBR_RATE_1X;
    end else if (!init_done) begin
      init_done <= 1'b1;
      mech_sba  <= mech_sba_i;
      agent_pci <= agent_pci_i;
      ext_gfx   <= ext_gfx_i && !agent_pci_i;
      agp_rate  <= agp_rate_i;
    end
  end

  assign lnk.init_valid = init_done;
  assign lnk.mech_sba   = mech_sba;
  assign lnk.agent_pci  = agent_pci;
  assign lnk.ext_gfx    = ext_gfx;
  assign lnk.agp_rate   = agp_rate;
  assign lnk.link_ver   = hbr_pkg::HBR_LINK_VER;

  assign host_ready_o = !host_v || lnk.host_ready;
  assign peer_ready_o = !peer_v || lnk.peer_ready;
  // A PCI agent has no request queue; nothing before settings freeze
  assign agpq_ready_o = init_done && !agent_pci && (!agpq_v || lnk.agpq_ready);

  always_comb begin
    next_host_v = host_v && !lnk.host_ready;
    next_host_q = host_q;
    next_peer_v = peer_v && !lnk.peer_ready;
    next_peer_q = peer_q;
    next_agpq_v = agpq_v && !lnk.agpq_ready;
    next_agpq_q = agpq_q;
    if (host_valid_i && host_ready_o) begin
      next_host_v = 1'b1;
      next_host_q = host_i;
    end
    if (peer_valid_i && peer_ready_o) begin
      next_peer_v = 1'b1;
      next_peer_q = peer_i;
      if (peer_i.src == hbr_pkg::HBR_PEER_AGP && agent_pci) begin
        next_peer_q.agp_sem = 1'b0;
      end
    end
    if (agpq_valid_i && agpq_ready_o) begin
      next_agpq_v         = 1'b1;
      next_agpq_q.hp      = agpq_hp_i;
      next_agpq_q.via_sba = mech_sba;
      next_agpq_q.wr      = agpq_wr_i;
      next_agpq_q.addr    = agpq_addr_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_v <= 1'b0;
      peer_v <= 1'b0;
      agpq_v <= 1'b0;
      host_q <= '0;
      peer_q <= '0;
      agpq_q <= '0;
    end else begin
      host_v <= next_host_v;
      peer_v <= next_peer_v;
      agpq_v <= next_agpq_v;
      host_q <= next_host_q;
      peer_q <= next_peer_q;
      agpq_q <= next_agpq_q;
    end
  end

  assign lnk.host_valid = host_v;
  assign lnk.host       = host_q;
  assign lnk.peer_valid = peer_v;
  assign lnk.peer       = peer_q;
  assign lnk.agpq_valid = agpq_v;
  assign lnk.agpq       = agpq_q;
endmodule : hbr_requester
`default_nettype wire

// ---- rtl/hbr_router.sv ----
/*
  Router end: decodes host, peer, graphics-queue and integrated graphics
  cycles to one target each, translates aperture hits, sets snoop, and
  arbitrates one cycle at a time onto a registered route output.
  Assumes the requester end on the dev modport and a sink on route_*.
*/
`default_nettype none
module hbr_router #(
  parameter int AGPQ_DEPTH = hbr_pkg::HBR_AGPQ_DEPTH,
  parameter int APER_PAGES = hbr_pkg::HBR_APER_PAGES
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // Requester end
  hbr_link_if.dev                   lnk,
  // Decode windows
  input  wire logic [31:0]          mem_top_i,
  input  wire logic [31:0]          agp_mem_base_i,
  input  wire logic [31:0]          agp_mem_limit_i,
  input  wire logic [31:0]          agp_io_base_i,
  input  wire logic [31:0]          agp_io_limit_i,
  input  wire logic [31:0]          aper_base_i,
  input  wire hbr_pkg::hbr_hclk_t   host_clk_sel_i,
  // Translation table write port
  input  wire logic                 gtt_we_i,
  input  wire logic [$clog2(APER_PAGES)-1:0] gtt_idx_i,
  input  wire logic [hbr_pkg::HBR_PFN_W-1:0] gtt_pfn_i,
  // Integrated graphics requests
  input  wire logic                 igu_valid_i,
  input  wire logic                 igu_wr_i,
  input  wire logic [31:0]          igu_addr_i,
  output logic                      igu_ready_o,
  output logic                      igu_enable_o,
  // Routed cycles
  output logic                      route_valid_o,
  output hbr_pkg::hbr_route_t       route_o,
  input  wire logic                 route_ready_i,
  // Status
  output logic                      mech_err_o,
  output logic                      cfg_err_o,
  output logic                      fast_write_ok_o,
  output logic [$clog2(AGPQ_DEPTH+1)-1:0] agpq_count_o
);
  localparam int PW = $clog2(AGPQ_DEPTH);
  localparam int CW = $clog2(AGPQ_DEPTH+1);
  localparam int IW = $clog2(APER_PAGES);
  localparam int PB = hbr_pkg::HBR_PAGE_BITS;

  if (AGPQ_DEPTH < 2 || (AGPQ_DEPTH & (AGPQ_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("AGPQ_DEPTH must be a power of two");
  end
  if (APER_PAGES < 2 || (APER_PAGES & (APER_PAGES - 1)) != 0) begin : g_aper_chk
    $error("APER_PAGES must be a power of two");
  end

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic aper_hit(input logic [31:0] a, input logic [31:0] base);
    logic [hbr_pkg::HBR_PFN_W-1:0] off;
    off = a[31:PB] - base[31:PB];
    aper_hit = (a[31:PB] >= base[31:PB]) && (off < hbr_pkg::HBR_PFN_W'(APER_PAGES));
  endfunction : aper_hit

  // Settings captured once; a change later must not reroute traffic
  logic            cfg_done, mech_sba, agent_pci, ext_gfx, link_ok;
  hbr_pkg::hbr_rate_t agp_rate;
  logic [hbr_pkg::HBR_PFN_W-1:0] gtt [APER_PAGES];
  hbr_pkg::hbr_agpq_req_t hp_mem [AGPQ_DEPTH];
  hbr_pkg::hbr_agpq_req_t np_mem [AGPQ_DEPTH];
  logic [PW-1:0]   hp_rd, hp_wr, np_rd, np_wr, next_hp_rd, next_hp_wr, next_np_rd, next_np_wr;
  logic [CW-1:0]   hp_cnt, np_cnt, next_hp_cnt, next_np_cnt;
  logic [1:0]      last, next_last;
  logic            next_route_valid, next_mech_err;
  hbr_pkg::hbr_route_t next_route, host_rt, peer_rt, agpq_rt, igu_rt;
  hbr_pkg::hbr_agpq_req_t agpq_head;
  logic [3:0]      req;
  logic            grant_any, push, push_ok;
  logic [1:0]      gsel;
  logic [1:0]      idx;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_done  <= 1'b0;
      mech_sba  <= 1'b0;
      agent_pci <= 1'b0;
      ext_gfx   <= 1'b0;
      link_ok   <= 1'b0;
      agp_rate  <= hbr_pkg::HBR_RATE_1X;
    end else if (!cfg_done && lnk.init_valid) begin
      cfg_done  <= 1'b1;
      mech_sba  <= lnk.mech_sba;
      agent_pci <= lnk.agent_pci;
      ext_gfx   <= lnk.ext_gfx;
      link_ok   <= (lnk.link_ver == hbr_pkg::HBR_LINK_VER);
      agp_rate  <= lnk.agp_rate;
    end
  end

  assign igu_enable_o    = cfg_done && !ext_gfx;
  assign fast_write_ok_o = cfg_done && !agent_pci && (agp_rate >= hbr_pkg::HBR_RATE_4X);
  assign cfg_err_o       = (host_clk_sel_i == hbr_pkg::HBR_HCLK_BAD);
  assign agpq_count_o    = CW'(hp_cnt + np_cnt);

  always_ff @(posedge clock_i) begin
    if (gtt_we_i) begin
      gtt[gtt_idx_i] <= gtt_pfn_i;
    end
  end

  // Host decode
  always_comb begin
    host_rt       = '0;
    host_rt.src   = hbr_pkg::HBR_SRC_HOST;
    host_rt.wr    = lnk.host.wr;
    host_rt.addr  = lnk.host.addr;
    host_rt.snoop = 1'b0;
    if (lnk.host.is_io) begin
      if (lnk.host.addr[31:2] == hbr_pkg::HBR_CFG_ADDR_PORT[31:2] ||
          lnk.host.addr[31:2] == hbr_pkg::HBR_CFG_DATA_PORT[31:2]) begin
        host_rt.tgt = hbr_pkg::HBR_TGT_CFG;
      end else if (in_range(lnk.host.addr, agp_io_base_i, agp_io_limit_i)) begin
        host_rt.tgt = hbr_pkg::HBR_TGT_AGP;
      end else begin
        host_rt.tgt = hbr_pkg::HBR_TGT_LINK;
      end
    end else if (aper_hit(lnk.host.addr, aper_base_i)) begin
      host_rt.tgt  = hbr_pkg::HBR_TGT_MEM;
      host_rt.addr = {gtt[IW'(lnk.host.addr[31:PB] - aper_base_i[31:PB])], lnk.host.addr[PB-1:0]};
    end else if (in_range(lnk.host.addr, agp_mem_base_i, agp_mem_limit_i)) begin
      host_rt.tgt = hbr_pkg::HBR_TGT_AGP;
    end else if (lnk.host.addr < mem_top_i) begin
      host_rt.tgt = hbr_pkg::HBR_TGT_MEM;
    end else begin
      host_rt.tgt = hbr_pkg::HBR_TGT_LINK;
    end
  end

  // Peer decode: graphics port, south link and LAN link masters
  always_comb begin
    peer_rt      = '0;
    peer_rt.src  = hbr_pkg::HBR_SRC_PEER;
    peer_rt.wr   = lnk.peer.wr;
    peer_rt.addr = lnk.peer.addr;
    peer_rt.tgt  = hbr_pkg::HBR_TGT_MEM;
    if (in_range(lnk.peer.addr, agp_mem_base_i, agp_mem_limit_i)) begin
      peer_rt.tgt  = hbr_pkg::HBR_TGT_AGP;
      peer_rt.drop = !(lnk.peer.src == hbr_pkg::HBR_PEER_HUB && lnk.peer.wr);
    end else if (lnk.peer.addr >= mem_top_i) begin
      peer_rt.tgt  = hbr_pkg::HBR_TGT_LINK;
      peer_rt.drop = 1'b1;
    end else if (lnk.peer.src == hbr_pkg::HBR_PEER_AGP) begin
      peer_rt.snoop = !lnk.peer.agp_sem && !lnk.peer.noncache;
    end else begin
      peer_rt.snoop = 1'b1;
    end
    // Link masters speaking another protocol version are not served
    if (lnk.peer.src != hbr_pkg::HBR_PEER_AGP && !link_ok) begin
      peer_rt.drop = 1'b1;
    end
  end

  // Graphics queue head: high priority first
  always_comb begin
    agpq_head      = (hp_cnt != '0) ? hp_mem[hp_rd] : np_mem[np_rd];
    agpq_rt        = '0;
    agpq_rt.src    = hbr_pkg::HBR_SRC_AGPQ;
    agpq_rt.tgt    = hbr_pkg::HBR_TGT_MEM;
    agpq_rt.wr     = agpq_head.wr;
    agpq_rt.snoop  = 1'b0;
    agpq_rt.addr   = agpq_head.addr;
    if (aper_hit(agpq_head.addr, aper_base_i)) begin
      agpq_rt.addr = {gtt[IW'(agpq_head.addr[31:PB] - aper_base_i[31:PB])], agpq_head.addr[PB-1:0]};
    end
    igu_rt       = '0;
    igu_rt.src   = hbr_pkg::HBR_SRC_IGU;
    igu_rt.tgt   = hbr_pkg::HBR_TGT_MEM;
    igu_rt.wr    = igu_wr_i;
    igu_rt.addr  = igu_addr_i;
  end

  // Round-robin pick among host, peer, queue and integrated graphics
  always_comb begin
    req       = {igu_valid_i && igu_enable_o, (hp_cnt != '0) || (np_cnt != '0), lnk.peer_valid, lnk.host_valid};
    grant_any = 1'b0;
    gsel      = last;
    idx       = '0;
    for (int k = 1; k <= 4; k++) begin
      idx = 2'(last + 2'(k));
      if (!grant_any && req[idx]) begin
        grant_any = 1'b1;
        gsel      = idx;
      end
    end
    grant_any = grant_any && (!route_valid_o || route_ready_i);
  end

  assign lnk.host_ready = grant_any && gsel == 2'(hbr_pkg::HBR_SRC_HOST);
  assign lnk.peer_ready = grant_any && gsel == 2'(hbr_pkg::HBR_SRC_PEER);
  assign igu_ready_o    = grant_any && gsel == 2'(hbr_pkg::HBR_SRC_IGU);
  // Level handshakes so the far side may answer late
  assign lnk.agpq_ready = cfg_done && !agent_pci && (agpq_count_o < CW'(AGPQ_DEPTH));

  always_comb begin
    push          = lnk.agpq_valid && lnk.agpq_ready;
    push_ok       = push && (lnk.agpq.via_sba == mech_sba);
    next_mech_err = push && !push_ok;
    next_hp_wr    = hp_wr;
    next_np_wr    = np_wr;
    next_hp_rd    = hp_rd;
    next_np_rd    = np_rd;
    next_hp_cnt   = hp_cnt;
    next_np_cnt   = np_cnt;
    if (push_ok && lnk.agpq.hp) begin
      next_hp_wr  = PW'(hp_wr + 1'b1);
      next_hp_cnt = CW'(next_hp_cnt + 1'b1);
    end else if (push_ok) begin
      next_np_wr  = PW'(np_wr + 1'b1);
      next_np_cnt = CW'(next_np_cnt + 1'b1);
    end
    if (grant_any && gsel == 2'(hbr_pkg::HBR_SRC_AGPQ)) begin
      if (hp_cnt != '0) begin
        next_hp_rd  = PW'(hp_rd + 1'b1);
        next_hp_cnt = CW'(next_hp_cnt - 1'b1);
      end else begin
        next_np_rd  = PW'(np_rd + 1'b1);
        next_np_cnt = CW'(next_np_cnt - 1'b1);
      end
    end
    next_last        = grant_any ? gsel : last;
    next_route_valid = grant_any || (route_valid_o && !route_ready_i);
    next_route       = route_o;
    if (grant_any) begin
      case (gsel)
        2'(hbr_pkg::HBR_SRC_HOST): next_route = host_rt;
        2'(hbr_pkg::HBR_SRC_PEER): next_route = peer_rt;
        2'(hbr_pkg::HBR_SRC_AGPQ): next_route = agpq_rt;
        default:                   next_route = igu_rt;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (push_ok && lnk.agpq.hp) begin
      hp_mem[hp_wr] <= lnk.agpq;
    end
    if (push_ok && !lnk.agpq.hp) begin
      np_mem[np_wr] <= lnk.agpq;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hp_rd         <= '0;
      hp_wr         <= '0;
      np_rd         <= '0;
      np_wr         <= '0;
      hp_cnt        <= '0;
      np_cnt        <= '0;
      last          <= 2'h3;
      route_valid_o <= 1'b0;
      route_o       <= '0;
      mech_err_o    <= 1'b0;
    end else begin
      hp_rd         <= next_hp_rd;
      hp_wr         <= next_hp_wr;
      np_rd         <= next_np_rd;
      np_wr         <= next_np_wr;
      hp_cnt        <= next_hp_cnt;
      np_cnt        <= next_np_cnt;
      last          <= next_last;
      route_valid_o <= next_route_valid;
      route_o       <= next_route;
      mech_err_o    <= next_mech_err;
    end
  end
endmodule : hbr_router
`default_nettype wire

// ---- verification/hbr_router_props.sv ----
/*
  Concurrent checks on the link carrier and the routed-cycle outputs.
  Assumes the bench instantiates it beside the carrier; one clock domain.
*/
`default_nettype none
module hbr_router_props (
  // Clock and reset
  input wire logic                   clock_i,
  input wire logic                   rst_n_i,
  // Carrier signals
  input wire logic                   host_valid,
  input wire logic                   host_ready,
  input wire hbr_pkg::hbr_host_req_t host,
  input wire logic                   peer_valid,
  input wire logic                   peer_ready,
  input wire logic                   agpq_valid,
  input wire logic                   agpq_ready,
  input wire hbr_pkg::hbr_agpq_req_t agpq,
  input wire logic                   init_valid,
  input wire logic                   mech_sba,
  input wire logic                   agent_pci,
  input wire logic                   ext_gfx,
  input wire logic [7:0]             link_ver,
  // Router outputs and sink
  input wire logic                   route_valid_o,
  input wire hbr_pkg::hbr_route_t    route_o,
  input wire logic                   route_ready_i,
  input wire logic [5:0]             agpq_count_o,
  input wire logic                   igu_enable_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_one_grant: assert property (
    !(host_valid && host_ready && peer_valid && peer_ready))
    else $error("host and peer granted together");
  a_stall_hold: assert property (
    route_valid_o && !route_ready_i |=> route_valid_o && $stable(route_o))
    else $error("stalled route changed");
  a_host_next: assert property (
    host_valid && host_ready |=> route_valid_o && route_o.src == hbr_pkg::HBR_SRC_HOST)
    else $error("host grant not routed next cycle");
  a_cfg_decode: assert property (
    host_valid && host_ready && host.is_io && host.addr[31:3] == 29'h0000_019f
    |=> route_o.tgt == hbr_pkg::HBR_TGT_CFG)
    else $error("config port not decoded");
  a_queue_nosnoop: assert property (
    route_valid_o && route_o.src == hbr_pkg::HBR_SRC_AGPQ
    |-> !route_o.snoop && route_o.tgt == hbr_pkg::HBR_TGT_MEM)
    else $error("queued cycle snooped or misrouted");
  a_peer_wr_only: assert property (
    route_valid_o && route_o.src == hbr_pkg::HBR_SRC_PEER && route_o.tgt == hbr_pkg::HBR_TGT_AGP
    && !route_o.drop |-> route_o.wr)
    else $error("peer read forwarded to graphics port");
  a_queue_cap: assert property (
    agpq_count_o == 6'h20 |-> !agpq_ready)
    else $error("full queue still accepting");
  a_pci_closed: assert property (
    agent_pci |-> !agpq_ready)
    else $error("queue open with bus agent");
  a_gfx_excl: assert property (
    init_valid && ext_gfx |-> ##1 !igu_enable_o)
    else $error("integrated graphics on with external card");
  a_mech_match: assert property (
    agpq_valid |-> agpq.via_sba == mech_sba)
    else $error("queue request on wrong mechanism");
  a_link_ver: assert property (
    init_valid |-> link_ver == 8'h10)
    else $error("link protocol version wrong");

  c_stall: cover property (route_valid_o && !route_ready_i);
  c_full: cover property (agpq_count_o == 6'h20);
  c_drop: cover property (route_valid_o && route_o.drop);
endmodule : hbr_router_props
`default_nettype wire

// ---- verification/tb_host_bridge_cycle_router.sv ----
/*
  Bench for the cycle router: requester and router joined by the carrier.
  Assumes package, carrier, both ends and the checker compiled first.
*/
`default_nettype none
module tb_host_bridge_cycle_router;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, rst_n_i = 1'b0, mech_sba_i = 1'b0, agent_pci_i = 1'b0, ext_gfx_i = 1'b0, fast_write_ok_o;
  logic host_valid_i = 1'b0, peer_valid_i = 1'b0, agpq_valid_i = 1'b0, agpq_hp_i = 1'b0, mech_err_o, cfg_err_o;
  logic agpq_wr_i = 1'b0, igu_valid_i = 1'b0, igu_wr_i = 1'b1, gtt_we_i = 1'b0, route_ready_i = 1'b1;
  logic [31:0] agpq_addr_i = 32'h0, igu_addr_i = 32'h0, mem_top_i = 32'h2000_0000;
  logic [31:0] agp_mem_base_i = 32'h3000_0000, agp_mem_limit_i = 32'h30ff_ffff, aper_base_i = 32'h4000_0000;
  logic [31:0] agp_io_base_i = 32'h0000_1000, agp_io_limit_i = 32'h0000_1fff;
  logic [3:0] gtt_idx_i = 4'h0;
  logic [19:0] gtt_pfn_i = 20'h0;
  hbr_pkg::hbr_rate_t agp_rate_i = hbr_pkg::HBR_RATE_1X;
  hbr_pkg::hbr_hclk_t host_clk_sel_i = hbr_pkg::HBR_HCLK_133;
  hbr_pkg::hbr_host_req_t host_i = '0;
  hbr_pkg::hbr_peer_req_t peer_i = '0;
  logic host_ready_o, peer_ready_o, agpq_ready_o, igu_ready_o, igu_enable_o, route_valid_o;
  logic [5:0] agpq_count_o;
  hbr_pkg::hbr_route_t route_o;
  int errors = 0, num_checks = 0;

  hbr_link_if lnk ();
  hbr_requester hbr_requester_i (.clock_i, .rst_n_i, .lnk, .mech_sba_i, .agent_pci_i, .ext_gfx_i,
    .agp_rate_i, .host_valid_i, .host_i, .host_ready_o, .peer_valid_i, .peer_i, .peer_ready_o,
    .agpq_valid_i, .agpq_hp_i, .agpq_wr_i, .agpq_addr_i, .agpq_ready_o);
  hbr_router hbr_router_i (.clock_i, .rst_n_i, .lnk, .mem_top_i, .agp_mem_base_i, .agp_mem_limit_i,
    .agp_io_base_i, .agp_io_limit_i, .aper_base_i, .host_clk_sel_i, .gtt_we_i, .gtt_idx_i, .gtt_pfn_i,
    .igu_valid_i, .igu_wr_i, .igu_addr_i, .igu_ready_o, .igu_enable_o, .route_valid_o, .route_o,
    .route_ready_i, .mech_err_o, .cfg_err_o, .fast_write_ok_o, .agpq_count_o);
  hbr_router_props hbr_router_props_i (.clock_i, .rst_n_i, .host_valid(lnk.host_valid),
    .host_ready(lnk.host_ready), .host(lnk.host), .peer_valid(lnk.peer_valid), .peer_ready(lnk.peer_ready),
    .agpq_valid(lnk.agpq_valid), .agpq_ready(lnk.agpq_ready), .agpq(lnk.agpq), .init_valid(lnk.init_valid),
    .mech_sba(lnk.mech_sba), .agent_pci(lnk.agent_pci), .ext_gfx(lnk.ext_gfx), .link_ver(lnk.link_ver),
    .route_valid_o, .route_o, .route_ready_i, .agpq_count_o, .igu_enable_o);

  always #25 clock_i = ~clock_i;

  task automatic chk(input logic [38:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic give_verdict;
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic nx;
    @(posedge clock_i);
    #1;
  endtask : nx

  task automatic wt(ref logic r);
    #1 for (int n = 0; n < 60 && r !== 1'b1; n++) nx; // Let combinational ready settle first
    chk(r, 1'b1);
  endtask : wt

  task automatic rx(input logic [1:0] s, t, input logic d, sn, w, input logic [31:0] a);
    logic [38:0] m;
    // Snoop only defined toward memory
    m = (t == 2'h0) ? '1 : ~(39'h1 << 33);
    wt(route_valid_o);
    chk(route_o & m, {s, t, d, sn, w, a} & m);
    nx;
  endtask : rx

  task automatic hs(input logic io, input logic [31:0] a, input logic [1:0] t, input logic [31:0] ea,
                    input bit r = 1'b1);
    host_i = '{io, 1'b0, a};
    host_valid_i = 1'b1;
    wt(host_ready_o);
    nx;
    host_valid_i = 1'b0;
    if (r) rx(2'h0, t, 1'b0, 1'b0, 1'b0, ea);
  endtask : hs

  task automatic rs(input logic m, pci, ext, input logic [1:0] r);
    rst_n_i = 1'b0;
    mech_sba_i = m;
    agent_pci_i = pci;
    ext_gfx_i = ext;
    agp_rate_i = hbr_pkg::hbr_rate_t'(r);
    repeat (4) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    repeat (3) nx;
  endtask : rs

  task automatic t_modes;
    for (int r = 0; r < 4; r++) begin
      rs(r[0], 1'b0, 1'b1, r[1:0]);
      chk(fast_write_ok_o, r >= 2);
      chk(igu_enable_o, 1'b0);
      chk(agpq_ready_o, 1'b1);
    end
    rs(1'b0, 1'b1, 1'b1, 2'h3);
    chk(agpq_ready_o, 1'b0);
    chk(igu_enable_o, 1'b1);
    chk(fast_write_ok_o, 1'b0);
    rs(1'b0, 1'b0, 1'b0, 2'h0);
  endtask : t_modes

  task automatic t_clk;
    for (int s = 3; s >= 0; s--) begin
      host_clk_sel_i = hbr_pkg::hbr_hclk_t'(s);
      nx;
      chk(cfg_err_o, s == 3);
    end
    chk(lnk.link_ver, 8'h10);
  endtask : t_clk

  task automatic t_host;
    gtt_idx_i = 4'h1;
    gtt_pfn_i = 20'h00abc;
    gtt_we_i = 1'b1;
    nx;
    gtt_we_i = 1'b0;
    hs(1'b1, 32'h0000_0cf8, 2'h3, 32'h0000_0cf8);
    hs(1'b1, 32'h0000_0cfc, 2'h3, 32'h0000_0cfc);
    hs(1'b1, 32'h0000_1800, 2'h1, 32'h0000_1800);
    hs(1'b1, 32'h0000_0060, 2'h2, 32'h0000_0060);
    hs(1'b0, 32'h4000_1234, 2'h0, 32'h00ab_c234);
    hs(1'b0, 32'h3000_0010, 2'h1, 32'h3000_0010);
    hs(1'b0, 32'h0000_0100, 2'h0, 32'h0000_0100);
    hs(1'b0, 32'hffff_fff0, 2'h2, 32'hffff_fff0);
  endtask : t_host

  task automatic t_peer;
    // Row: source, agp semantics, uncached, write, in window, target, drop, snoop
    logic [9:0] pt [9] = '{10'h040, 10'h021, 10'h080, 10'h101, 10'h221, 10'h134, 10'h116, 10'h036, 10'h236};
    logic [31:0] a;
    foreach (pt[i]) begin
      a = pt[i][4] ? 32'h3000_0040 : 32'h0000_0200;
      peer_i = '{hbr_pkg::hbr_peer_t'(pt[i][9:8]), pt[i][7], pt[i][6], pt[i][5], a};
      peer_valid_i = 1'b1;
      wt(peer_ready_o);
      nx;
      peer_valid_i = 1'b0;
      rx(2'h1, pt[i][3:2], pt[i][1], pt[i][0], pt[i][5], a);
    end
  endtask : t_peer

  // Stalled sink lets the queue fill; one extra entry waits in the requester
  task automatic t_queue;
    route_ready_i = 1'b0;
    hs(1'b0, 32'h0000_0100, 2'h0, 32'h0, 1'b0);
    agpq_valid_i = 1'b1;
    for (int i = 0; i < 33; i++) begin
      agpq_hp_i = (i == 1);
      agpq_wr_i = i[0];
      agpq_addr_i = (i == 1) ? 32'h0000_9000 : 32'h0000_2000 + 32'(i) * 16;
      wt(agpq_ready_o);
      nx;
    end
    agpq_valid_i = 1'b0;
    chk(agpq_count_o, 6'h20);
    chk(agpq_ready_o, 1'b0);
    chk(mech_err_o, 1'b0);
    route_ready_i = 1'b1;
    rx(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0000_0100);
    rx(2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 32'h0000_9000);
    for (int i = 0; i < 33; i++) if (i != 1) rx(2'h2, 2'h0, 1'b0, 1'b0, i[0], 32'h0000_2000 + 32'(i) * 16);
  endtask : t_queue

  task automatic t_arb;
    host_i = '{1'b0, 1'b0, 32'h0000_0300};
    peer_i = '{hbr_pkg::HBR_PEER_HUB, 1'b0, 1'b0, 1'b0, 32'h0000_0400};
    host_valid_i = 1'b1;
    peer_valid_i = 1'b1;
    nx;
    host_valid_i = 1'b0;
    peer_valid_i = 1'b0;
    rx(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0000_0300);
    rx(2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 32'h0000_0400);
    igu_addr_i = 32'h0000_0500;
    igu_valid_i = 1'b1;
    wt(igu_ready_o);
    nx;
    igu_valid_i = 1'b0;
    rx(2'h3, 2'h0, 1'b0, 1'b0, 1'b1, 32'h0000_0500);
  endtask : t_arb

  initial begin
    t_modes;
    t_clk;
    t_host;
    t_peer;
    t_queue;
    t_arb;
    give_verdict;
  end

  // Roughly twenty-three times the expected run
  initial begin
    #200000;
    errors++;
    give_verdict;
  end
endmodule : tb_host_bridge_cycle_router
`default_nettype wire
